/* File: shared/emdp_consts.svh */
// Offsets, field positions, reset values and codes of the EA decode block.
// Assumes inclusion by the core module only, once.
`ifndef EMDP_CONSTS_SVH
`define EMDP_CONSTS_SVH
// APB byte offsets
`define EMDP_OFF_SW 8'h00
`define EMDP_OFF_CCB 8'h04
`define EMDP_OFF_VTB 8'h08
`define EMDP_OFF_CACHE_CONTROL_REG 8'h0C
`define EMDP_OFF_ACCESS_CONTROL_REG_0 8'h10
`define EMDP_OFF_ACCESS_CONTROL_REG_1 8'h14
`define EMDP_OFF_DSTAT 8'h18
`define EMDP_GPR_BASE 2'h1
// Status word, vector base, cache and access control fields and reset values
`define EMDP_SW_S 13
`define EMDP_SW_RST 16'h2700
`define EMDP_VTB_LSB 20
`define EMDP_CACHE_CONTROL_REG_EN 31
`define EMDP_ACR_EN 15
`define EMDP_CACHE_CONTROL_REG_RST 32'h0000_0000
`define EMDP_ACR_RST 32'h0000_0000
// Mode field codes
`define EMDP_M_DREG 3'h0
`define EMDP_M_AREG 3'h1
`define EMDP_M_IND 3'h2
`define EMDP_M_PINC 3'h3
`define EMDP_M_PDEC 3'h4
`define EMDP_M_D16 3'h5
`define EMDP_M_IDX 3'h6
`define EMDP_M_EXT 3'h7
// Sub-codes under the extended mode
`define EMDP_X_ABSW 3'h0
`define EMDP_X_ABSL 3'h1
`define EMDP_X_PCD 3'h2
`define EMDP_X_PCX 3'h3
`define EMDP_X_IMM 3'h4
// Count of supported multiply-accumulate instructions
`define EMDP_MAC_CNT 4'h9
`endif

/* File: shared/emdp_pkg.sv */
// Types shared by the EA decode and privilege block.
// Assumes the constants header is on the include path.
`default_nettype none
package emdp_pkg;
	typedef enum logic [3:0] {
		ACC_DREG, ACC_AREG, ACC_IND, ACC_PINC, ACC_PDEC, ACC_D16,
		ACC_IDX, ACC_ABSW, ACC_ABSL, ACC_PCD, ACC_PCX, ACC_IMM, ACC_ILL
	} emdp_acc_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_BIT} emdp_size_t;
	typedef enum logic [2:0] {
		OP_GEN, OP_BCD, OP_BITFLD, OP_ROT, OP_DBRA, OP_MUL64, OP_MAC
	} emdp_op_t;
	typedef struct packed {
		logic valid;
		logic [2:0] mode;
		logic [2:0] regf;
		emdp_size_t size;
		emdp_op_t op;
		logic [3:0] mac_sel;
		logic [31:0] imm;
		logic [3:0] idx_sel;
	} emdp_dreq_t;
	typedef struct packed {
		logic valid;
		emdp_acc_t acc;
		logic [2:0] regno;
		logic [1:0] ext_words;
		logic illegal;
		logic unsupported;
		logic [31:0] imm_ext;
		logic [31:0] idx_val;
	} emdp_dres_t;
	typedef struct packed {
		logic entry;
		logic [7:0] vector;
		logic return_from_exception;
		logic [15:0] rte_sw;
		logic [31:0] fetch_addr;
	} emdp_exc_t;
	typedef struct packed {
		logic supervisor;
		logic push_valid;
		logic [15:0] push_sw;
		logic flush;
		logic [31:0] vector_addr;
		logic cache_en;
		logic noncacheable;
		logic priv_viol;
	} emdp_priv_t;
endpackage
`default_nettype wire

/* File: rtl/emdp_core.sv */
// EA mode decoder and privilege state with an APB register slave.
// Assumes all non-APB inputs come from logic on pclk.
//
// What this block does
// - Mode 111: short, long absolute, immediate
// - Modes 000/001: data or address register direct
// - Modes 010-101: indirect, postinc, predec, displacement
// - Mode 110: indexed indirect, 8-bit displacement
// - Mode 111 sub 010/011: PC relative forms
// - Exception entry pushes status, then sets supervisor
// - Supervisor flag change by status write or return flushes fetch pipeline; exception entry does not
// - Vector base keeps upper 12 bits only
// - Condition byte user-visible; control byte supervisor-only
// - Sixteen 32-bit registers, any usable as index
// - Five supervisor registers need a privileged APB access (pprot[0])
// - Cache enable; two noncacheable address windows
// - Bit, byte, word, longword operand sizes
// - Two's complement arithmetic, signed extension available
// - Drop removed instruction classes; nine MAC ops
// - Supervisor flag sets privilege; changers are privileged
`include "emdp_consts.svh"
`default_nettype none
module emdp_core (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0] pprot,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decode request and result
	input wire emdp_pkg::emdp_dreq_t dreq,
	output emdp_pkg::emdp_dres_t dres,
	// Exception events and privilege state
	input wire emdp_pkg::emdp_exc_t exc,
	output emdp_pkg::emdp_priv_t priv
);
	import emdp_pkg::*;

	typedef struct packed {
		logic [15:0] sw;
		logic [11:0] vtb;
		logic [31:0] cache_control_reg;
		logic [31:0] access_control_reg_0;
		logic [31:0] access_control_reg_1;
		logic [15:0][31:0] gpr;
		emdp_dres_t dec;
		emdp_priv_t po;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} emdp_state_t;

	emdp_state_t s_r;
	emdp_state_t s_nxt;

	// Address window match of one access control register
	function automatic logic acr_hit(input logic [31:0] acr, input logic [31:0] a);
		acr_hit = acr[`EMDP_ACR_EN] && (((a[31:24] ^ acr[31:24]) & ~acr[23:16]) == 8'h00);
	endfunction

	logic setup;
	logic done;
	logic is_priv;
	logic gpr_hit;
	logic [3:0] gpr_idx;
	logic sup_only;
	logic mapped;
	logic [31:0] rd;
	logic [15:0] sw_new;
	logic sw_chg;

	// APB phase and address decode
	always_comb begin
		setup = psel && !penable;
		done = psel && penable && s_r.pready;
		is_priv = pprot[0];
		gpr_hit = (paddr[7:6] == `EMDP_GPR_BASE) && (paddr[1:0] == 2'h0);
		gpr_idx = paddr[5:2];
		// Defaults: user-visible and mapped
		sup_only = 1'b0;
		mapped = 1'b1;
		rd = 32'h0000_0000;
		// Read mux; supervisor-only offsets marked for refusal
		if (gpr_hit) begin
			rd = s_r.gpr[gpr_idx];
		end else begin
			unique case (paddr)
				`EMDP_OFF_SW: begin
					rd = {16'h0000, s_r.sw};
					sup_only = 1'b1;
				end
				`EMDP_OFF_CCB: begin
					rd = {24'h00_0000, s_r.sw[7:0]};
				end
				`EMDP_OFF_VTB: begin
					rd = {s_r.vtb, 20'h0_0000};
					sup_only = 1'b1;
				end
				`EMDP_OFF_CACHE_CONTROL_REG: begin
					rd = s_r.cache_control_reg;
					sup_only = 1'b1;
				end
				`EMDP_OFF_ACCESS_CONTROL_REG_0: begin
					rd = s_r.access_control_reg_0;
					sup_only = 1'b1;
				end
				`EMDP_OFF_ACCESS_CONTROL_REG_1: begin
					rd = s_r.access_control_reg_1;
					sup_only = 1'b1;
				end
				`EMDP_OFF_DSTAT: begin
					rd = {21'h00_0000, s_r.dec.unsupported, s_r.dec.illegal,
						s_r.dec.ext_words, s_r.dec.regno, s_r.dec.acc};
				end
				default: begin
					mapped = 1'b0;
				end
			endcase
		end
	end

	// Next state of the whole block
	always_comb begin
		s_nxt = s_r;
		s_nxt.pready = setup;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = 32'h0000_0000;
		// One-cycle pulses drop unless raised below
		s_nxt.po.push_valid = 1'b0;
		s_nxt.po.flush = 1'b0;
		s_nxt.po.priv_viol = 1'b0;
		// Status candidate, applied once after all sources
		sw_new = s_r.sw;
		sw_chg = 1'b0;

		// Setup cycle: answer prepared, supervisor-only regs refused to user
		if (setup) begin
			s_nxt.pslverr = !mapped || (sup_only && !is_priv);
			s_nxt.prdata = (mapped && !(sup_only && !is_priv) && !pwrite) ? rd : 32'h0000_0000;
			s_nxt.po.priv_viol = mapped && sup_only && !is_priv;
		end

		// Access cycle: writes take effect
		if (done && pwrite && !s_r.pslverr) begin
			if (gpr_hit) begin
				s_nxt.gpr[gpr_idx] = pwdata;
			end else begin
				unique case (paddr)
					`EMDP_OFF_SW: begin
						sw_new = pwdata[15:0];
						sw_chg = 1'b1;
					end
					`EMDP_OFF_CCB: begin
						sw_new = {s_r.sw[15:8], pwdata[7:0]};
						sw_chg = 1'b1;
					end
					`EMDP_OFF_VTB: s_nxt.vtb = pwdata[31:`EMDP_VTB_LSB];
					`EMDP_OFF_CACHE_CONTROL_REG: s_nxt.cache_control_reg = pwdata;
					`EMDP_OFF_ACCESS_CONTROL_REG_0: s_nxt.access_control_reg_0 = pwdata;
					`EMDP_OFF_ACCESS_CONTROL_REG_1: s_nxt.access_control_reg_1 = pwdata;
					default: begin
					end
				endcase
			end
		end

		// Return from exception only in supervisor mode
		if (exc.return_from_exception) begin
			if (s_r.sw[`EMDP_SW_S]) begin
				sw_new = exc.rte_sw;
				sw_chg = 1'b1;
			end else begin
				s_nxt.po.priv_viol = 1'b1;
			end
		end

		// Status update and flush on supervisor flag change
		if (sw_chg) begin
			s_nxt.sw = sw_new;
			s_nxt.po.flush = sw_new[`EMDP_SW_S] != s_r.sw[`EMDP_SW_S];
		end

		// Exception entry wins: push old status, then supervisor
		if (exc.entry) begin
			s_nxt.po.push_valid = 1'b1;
			s_nxt.po.push_sw = s_r.sw;
			s_nxt.sw = s_r.sw;
			s_nxt.sw[`EMDP_SW_S] = 1'b1;
			s_nxt.po.flush = 1'b0;
			s_nxt.po.vector_addr = {s_r.vtb, 10'h000, exc.vector, 2'h0};
		end
		s_nxt.po.supervisor = s_nxt.sw[`EMDP_SW_S];

		// Cache enable and noncacheable windows
		s_nxt.po.cache_en = s_r.cache_control_reg[`EMDP_CACHE_CONTROL_REG_EN];
		s_nxt.po.noncacheable = acr_hit(s_r.access_control_reg_0, exc.fetch_addr) ||
			acr_hit(s_r.access_control_reg_1, exc.fetch_addr);

		// Effective address decode
		s_nxt.dec.valid = dreq.valid;
		if (dreq.valid) begin
			// Defaults before the mode decode
			s_nxt.dec.regno = dreq.regf;
			s_nxt.dec.ext_words = 2'h0;
			s_nxt.dec.acc = ACC_ILL;
			unique case (dreq.mode)
				`EMDP_M_DREG: s_nxt.dec.acc = ACC_DREG;
				`EMDP_M_AREG: s_nxt.dec.acc = ACC_AREG;
				`EMDP_M_IND: s_nxt.dec.acc = ACC_IND;
				`EMDP_M_PINC: s_nxt.dec.acc = ACC_PINC;
				`EMDP_M_PDEC: s_nxt.dec.acc = ACC_PDEC;
				`EMDP_M_D16: begin
					s_nxt.dec.acc = ACC_D16;
					s_nxt.dec.ext_words = 2'h1;
				end
				`EMDP_M_IDX: begin
					s_nxt.dec.acc = ACC_IDX;
					s_nxt.dec.ext_words = 2'h1;
				end
				`EMDP_M_EXT: begin
					s_nxt.dec.regno = 3'h0;
					unique case (dreq.regf)
						`EMDP_X_ABSW: begin
							s_nxt.dec.acc = ACC_ABSW;
							s_nxt.dec.ext_words = 2'h1;
						end
						`EMDP_X_ABSL: begin
							s_nxt.dec.acc = ACC_ABSL;
							s_nxt.dec.ext_words = 2'h2;
						end
						`EMDP_X_PCD: begin
							s_nxt.dec.acc = ACC_PCD;
							s_nxt.dec.ext_words = 2'h1;
						end
						`EMDP_X_PCX: begin
							s_nxt.dec.acc = ACC_PCX;
							s_nxt.dec.ext_words = 2'h1;
						end
						`EMDP_X_IMM: begin
							s_nxt.dec.acc = ACC_IMM;
							s_nxt.dec.ext_words = (dreq.size == SZ_LONG) ? 2'h2 : 2'h1;
						end
						default: s_nxt.dec.acc = ACC_ILL;
					endcase
				end
				default: s_nxt.dec.acc = ACC_ILL;
			endcase
			// Illegal forms carry no register or extension words
			s_nxt.dec.illegal = s_nxt.dec.acc == ACC_ILL;
			if (s_nxt.dec.illegal) begin
				s_nxt.dec.regno = 3'h0;
				s_nxt.dec.ext_words = 2'h0;
			end
			// Removed classes and MAC selector range
			unique case (dreq.op)
				OP_GEN: s_nxt.dec.unsupported = 1'b0;
				OP_MAC: s_nxt.dec.unsupported = dreq.mac_sel >= `EMDP_MAC_CNT;
				default: s_nxt.dec.unsupported = 1'b1;
			endcase
			// Two's complement extension by operand size
			unique case (dreq.size)
				SZ_BYTE: s_nxt.dec.imm_ext = {{24{dreq.imm[7]}}, dreq.imm[7:0]};
				SZ_WORD: s_nxt.dec.imm_ext = {{16{dreq.imm[15]}}, dreq.imm[15:0]};
				SZ_LONG: s_nxt.dec.imm_ext = dreq.imm;
				SZ_BIT: s_nxt.dec.imm_ext = {31'h0000_0000, dreq.imm[0]};
			endcase
			// Index register as held at the request edge
			s_nxt.dec.idx_val = s_r.gpr[dreq.idx_sel];
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.sw <= `EMDP_SW_RST;
			s_r.cache_control_reg <= `EMDP_CACHE_CONTROL_REG_RST;
			s_r.access_control_reg_0 <= `EMDP_ACR_RST;
			s_r.access_control_reg_1 <= `EMDP_ACR_RST;
			// Core starts privileged, matching the status reset
			s_r.po.supervisor <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign dres = s_r.dec;
	assign priv = s_r.po;
endmodule
`default_nettype wire

/* File: verification/emdp_core_chk.sv */
// Checker: decode, privilege and APB refusal properties of emdp_core.
// Assumes it is bound onto emdp_core and sees only its ports.
`default_nettype none
module emdp_core_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0] pprot,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Decode and privilege
	input wire emdp_pkg::emdp_dreq_t dreq,
	input wire emdp_pkg::emdp_dres_t dres,
	input wire emdp_pkg::emdp_exc_t exc,
	input wire emdp_pkg::emdp_priv_t priv
);
	import emdp_pkg::*;
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Register, indirect and indexed modes
	property p_reg_modes;
		dreq.valid && dreq.mode != 3'h7 |=> !dres.illegal && dres.regno == $past(dreq.regf)
			&& dres.acc == {1'b0, $past(dreq.mode)};
	endproperty
	a_reg_modes: assert property (p_reg_modes) else $error("reg mode");
	// Absolute and immediate forms
	property p_abs_imm;
		dreq.valid && dreq.mode == 3'h7 && dreq.regf inside {3'h0, 3'h1, 3'h4}
			|=> dres.acc == 4'(4'h7 + $past(dreq.regf));
	endproperty
	a_abs_imm: assert property (p_abs_imm) else $error("abs mode");
	// Program counter relative forms
	property p_pc_rel;
		dreq.valid && dreq.mode == 3'h7 && dreq.regf inside {3'h2, 3'h3}
			|=> dres.acc == ($past(dreq.regf[0]) ? ACC_PCX : ACC_PCD);
	endproperty
	a_pc_rel: assert property (p_pc_rel) else $error("pc mode");
	// Unlisted sub-codes give no access
	property p_illegal;
		dreq.valid && dreq.mode == 3'h7 && dreq.regf > 3'h4 |=> dres.illegal && dres.acc == ACC_ILL;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal mode");
	// Entry pushes status and enters supervisor
	property p_entry;
		exc.entry |=> priv.push_valid && priv.supervisor && !priv.flush;
	endproperty
	a_entry: assert property (p_entry) else $error("entry");
	// Return from user mode refused
	property p_user_rte;
		exc.return_from_exception && !exc.entry && !priv.supervisor |=> priv.priv_viol && !priv.supervisor;
	endproperty
	a_user_rte: assert property (p_user_rte) else $error("user return");
	// Vector base low bits read zero
	property p_vtb_low;
		pready && !pwrite && paddr == 8'h08 |-> prdata[19:0] == 20'h0_0000;
	endproperty
	a_vtb_low: assert property (p_vtb_low) else $error("vector base");
	// User access to the status word refused
	property p_user_sw;
		psel && !penable && !pprot[0] && paddr == 8'h00 |=> pready && pslverr;
	endproperty
	a_user_sw: assert property (p_user_sw) else $error("user status");
endmodule
bind emdp_core emdp_core_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pprot, .prdata, .pready, .pslverr, .dreq, .dres, .exc, .priv);
`default_nettype wire

/* File: verification/emdp_core_tb.sv */
// Testbench: APB, exception and decode scenarios for emdp_core.
// Assumes package, design and checker are compiled before it.
`default_nettype none
module emdp_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import emdp_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [2:0] pprot = 3'h0;
	logic [31:0] pwdata = 32'h0000_0000, prdata, d;
	logic pready, pslverr;
	emdp_dreq_t dreq = '0;
	emdp_dres_t dres;
	emdp_exc_t exc = '0;
	emdp_priv_t priv;
	integer seed = 32'h0000_7d8a;
	int err_total = 0, cmp_count = 0, cycles = 0;
	logic [32:0] q_apb[$];
	logic [75:0] q_dec[$];
	// Block under test
	emdp_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata,
		.pready, .pslverr, .dreq, .dres, .exc, .priv);
	// Clock
	initial begin
		forever #4 pclk = ~pclk;
	end
	// Verdict
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Comparison bookkeeping and per-kind compares
	task automatic tally(input logic ok, input string what);
		cmp_count++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic cmp_apb(input logic [32:0] got, exp);
		tally(got === exp, "apb answer");
	endtask
	task automatic cmp_dec(input logic [75:0] got, exp);
		tally(exp[75] ? got[74:0] === exp[74:0] :
			{got[74:70], got[66:0]} === {exp[74:70], exp[66:0]}, "decode");
	endtask
	task automatic cmp_priv(input logic [31:0] got, exp);
		tally(got === exp, "privilege");
	endtask
	// Oldest note against each result; hang limit
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			report_and_stop();
		end else begin
			if (dres.valid === 1'b1)
				cmp_dec({1'b0, dres.acc, dres.illegal, dres.regno, dres.unsupported, dres.ext_words,
					dres.imm_ext, dres.idx_val},
					q_dec.pop_front());
			if (psel && penable && pready === 1'b1)
				cmp_apb({pslverr, pwrite ? 32'h0000_0000 : prdata}, q_apb.pop_front());
		end
	end
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic p,
		input logic [32:0] exp);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		pprot <= {2'b00, p};
		q_apb.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// One exception event, then privilege flags and pushed word
	task automatic exc_pulse(input logic e, r, input logic [15:0] sw, input logic [19:0] exp);
		exc <= '{e, 8'h40, r, sw, 32'h0000_0000};
		@(posedge pclk);
		exc <= '0;
		@(negedge pclk);
		cmp_priv({priv.push_valid, priv.supervisor, priv.flush, priv.priv_viol, priv.push_sw},
			exp);
		@(posedge pclk);
	endtask
	// One decode request with random size, class and immediate
	task automatic dec(input logic [2:0] m, r);
		emdp_op_t op;
		logic [3:0] ms;
		logic [3:0] acc;
		logic [31:0] imm;
		logic [31:0] ie;
		logic [1:0] ew;
		op = emdp_op_t'($unsigned($random(seed)) % 7);
		ms = $random(seed);
		imm = $random(seed);
		acc = m < 3'h7 ? {1'b0, m} : (r <= 3'h4 ? 4'h7 + r : 4'hC);
		ew = 2'h0;
		if (m == 3'h5 || m == 3'h6 || (m == 3'h7 && (r == 3'h0 || r == 3'h2 || r == 3'h3)))
			ew = 2'h1;
		if (m == 3'h7 && r == 3'h1)
			ew = 2'h2;
		if (m == 3'h7 && r == 3'h4)
			ew = (ms[1:0] == 2'h2) ? 2'h2 : 2'h1;
		case (ms[1:0])
			2'h0: ie = {{24{imm[7]}}, imm[7:0]};
			2'h1: ie = {{16{imm[15]}}, imm[15:0]};
			2'h2: ie = imm;
			default: ie = {31'h0000_0000, imm[0]};
		endcase
		dreq <= '{1'b1, m, r, emdp_size_t'(ms[1:0]), op, ms, imm, ms};
		q_dec.push_back({m < 3'h7, acc, acc == 4'hC, m < 3'h7 ? r : 3'h0,
			op == OP_MAC ? ms >= 4'h9 : op != OP_GEN, ew, ie, ms == 4'hF ? d : 32'h0000_0000});
		@(posedge pclk);
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 8'h00, 0, 1, 33'h0_0000_2700);
		apb(1, 8'h04, 32'h0000_00A5, 0, '0);
		apb(0, 8'h04, 0, 0, 33'h0_0000_00A5);
		apb(1, 8'h00, 0, 0, 33'h1_0000_0000);
		apb(0, 8'h08, 0, 0, 33'h1_0000_0000);
		apb(0, 8'h00, 0, 1, 33'h0_0000_27A5);
		apb(0, 8'h1C, 0, 1, 33'h1_0000_0000);
		d = $random(seed);
		apb(1, 8'h08, d, 1, '0);
		apb(0, 8'h08, 0, 1, {1'b0, d & 32'hFFF0_0000});
		apb(1, 8'h7C, d, 0, '0);
		apb(0, 8'h7C, 0, 0, {1'b0, d});
		apb(1, 8'h0C, 32'h8000_0000, 1, '0);
		@(negedge pclk);
		cmp_priv(priv.cache_en, 1);
		@(posedge pclk);
		exc_pulse(0, 1, 16'h0705, 20'h2_0000);
		exc_pulse(0, 1, 16'h2700, 20'h1_0000);
		exc_pulse(1, 0, 16'h0000, 20'hC_0705);
		cmp_priv(priv.vector_addr, d & 32'hFFF0_0000 | 32'h0000_0100);
		apb(1, 8'h10, 32'hA000_8000, 1, '0);
		exc.fetch_addr <= 32'hA012_3456;
		@(posedge pclk);
		exc.fetch_addr <= 32'h5000_0000;
		@(negedge pclk);
		cmp_priv(priv.noncacheable, 1);
		@(negedge pclk);
		cmp_priv(priv.noncacheable, 0);
		@(posedge pclk);
		apb(0, 8'h00, 0, 1, 33'h0_0000_2705);
		for (int i = 0; i < 64; i++)
			dec(i[5:3], i[2:0]);
		dreq.valid <= 1'b0;
		repeat (3) @(posedge pclk);
		tally(q_dec.size() == 0 && q_apb.size() == 0, "results missing");
		report_and_stop();
	end
endmodule
`default_nettype wire
